// *** common/fspr_params.svh ***
// Purpose: constants of the flash suspend, protect and reset command layer
// Assumes: 50 MHz core clock
// Notes: opcodes, field positions, reset values and timing counts
`ifndef FSPR_PARAMS_SVH
`define FSPR_PARAMS_SVH
// =====================================================================
// opcodes
`define FSPR_OP_GANG_LOCK 8'h7e
`define FSPR_OP_GANG_UNLOCK 8'h98
`define FSPR_OP_WRITE_ENABLE_CMD 8'h06
`define FSPR_OP_WRITE_DISABLE_CMD 8'h04
`define FSPR_OP_SUSPEND 8'hb0
`define FSPR_OP_RESUME 8'h30
`define FSPR_OP_NOP 8'h00
`define FSPR_OP_RST_ARM 8'h66
`define FSPR_OP_RST 8'h99
`define FSPR_OP_PARAM_RD 8'h5a
// =====================================================================
// geometry and fields
`define FSPR_SECTORS 16
`define FSPR_ADDR_W 28
`define FSPR_PAGE_LSB 8
`define FSPR_SECTOR_LSB 12
`define FSPR_SEC_PSB 2
`define FSPR_SEC_ESB 3
`define FSPR_ST_WIP 0
`define FSPR_ST_WEL 1
`define FSPR_VLOCK_RST 16'hffff
`define FSPR_PARAM_HDR 3'h5
// =====================================================================
// timing
`define FSPR_CLK_NS 20
`define FSPR_T_PSL_NS 20000
`define FSPR_T_ESL_NS 20000
`define FSPR_PSL_CYC ((`FSPR_T_PSL_NS + `FSPR_CLK_NS - 1) / `FSPR_CLK_NS)
`define FSPR_ESL_CYC ((`FSPR_T_ESL_NS + `FSPR_CLK_NS - 1) / `FSPR_CLK_NS)
`endif

// *** common/fspr_pkg.sv ***
// Purpose: types of the flash suspend, protect and reset command layer
// Assumes: nothing
// Notes: constants live in fspr_params.svh
package fspr_pkg;
  // =====================================================================
  // suspend state machine, one-hot
  typedef enum logic [3:0] {
    FSPR_IDLE = 4'b0001,
    FSPR_RUN = 4'b0010,
    FSPR_HALTING = 4'b0100,
    FSPR_HALTED = 4'b1000
  } fspr_state_t;
  // forwarded command towards the rest of the chip
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } fspr_cmd_t;
endpackage : fspr_pkg

// *** hdl/fspr_core.sv ***
// Purpose: command layer for gang protect, suspend/resume, nop, soft reset, param read
// Assumes: serial or quad one-byte commands, link clock sclk_in, array engine outside
// Notes: link side on sclk_in, command execution on mclk_in
`timescale 1ns/1ps
`include "fspr_params.svh"
module fspr_core (
  input wire logic mclk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic ce_in, // core clock enable
  input wire logic sclk_in, // link clock
  input wire logic cs_n_in, // chip select, active low
  input wire logic [3:0] sio_in, // data lines in
  output logic so_out, // serial data out
  output logic so_oe_n_out, // data out enable, low drives
  input wire logic quad_mode_in, // four-wire command mode
  input wire logic perf_mode_in, // performance enhance mode active
  input wire logic protect_select_in, // per-sector protection selected
  input wire logic [`FSPR_SECTORS-1:0] nonvolatile_lock_in, // nonvolatile locks
  input wire logic pe_start_in, // program or erase starts, pulse
  input wire logic pe_erase_in, // running op is erase
  input wire logic pe_done_in, // op finished, pulse
  input wire logic [`FSPR_ADDR_W-1:0] pe_addr_in, // address of running op
  input wire logic [`FSPR_ADDR_W-1:0] rd_addr_in, // array read address
  input wire logic [7:0] param_byte_in, // table byte at param_addr_out
  output logic [`FSPR_ADDR_W-1:0] param_addr_out, // table address
  output logic [`FSPR_SECTORS-1:0] volatile_lock_out, // volatile locks
  output logic [`FSPR_SECTORS-1:0] writable_out, // sector writable
  output logic read_allowed_out, // read address permitted
  output logic [7:0] status_out, // status byte
  output logic [7:0] security_out, // security status byte
  output logic pe_hold_out, // hold array engine
  output logic pe_abort_out, // abort array engine, pulse
  output fspr_pkg::fspr_cmd_t cmd_fwd_out // every command frame except refused ones and the armed reset, pulse
);
  import fspr_pkg::*;

  // =====================================================================
  // link domain: byte receive
  logic [2:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] rx_byte;
  logic [2:0] byte_idx;
  logic [7:0] link_op;
  logic stream;
  logic start_tgl;
  logic done_tgl;
  logic [2:0] quad_sy;
  logic quad_l;
  logic last_bit;
  logic [7:0] next_shreg;

  // quad command mode crosses into the link domain
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quad_sy <= 3'h0;
      quad_l <= 1'b0;
    end else begin
      quad_sy <= {quad_sy[1:0], quad_mode_in};
      if (quad_sy[1] == quad_sy[2]) begin
        quad_l <= quad_sy[2];
      end
    end
  end

  // upper lines ignored in serial mode
  assign last_bit = quad_l ? (bitcnt == 3'h1) : (bitcnt == 3'h7);
  assign next_shreg = quad_l ? {shreg[3:0], sio_in} : {shreg[6:0], sio_in[0]};

  // bit and byte counting, cleared by deselect
  always_ff @(posedge sclk_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in || cs_n_in) begin
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      byte_idx <= 3'h0;
      link_op <= 8'h00;
      stream <= 1'b0;
    end else begin
      shreg <= next_shreg;
      bitcnt <= last_bit ? 3'h0 : bitcnt + 3'h1;
      if (last_bit) begin
        if (byte_idx == 3'h0) begin
          link_op <= next_shreg;
        end
        if (byte_idx != `FSPR_PARAM_HDR) begin
          byte_idx <= byte_idx + 3'h1;
        end
        // opcode, three address bytes and a dummy byte, then data
        if (byte_idx == `FSPR_PARAM_HDR - 3'h1 && link_op == `FSPR_OP_PARAM_RD && !quad_l) begin
          stream <= 1'b1;
        end
      end
    end
  end

  // byte events for the core; data held stable for a whole byte time
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_tgl <= 1'b0;
      done_tgl <= 1'b0;
      rx_byte <= 8'h00;
    end else if (!cs_n_in) begin
      if (bitcnt == 3'h0) begin
        start_tgl <= ~start_tgl;
      end
      if (last_bit) begin
        done_tgl <= ~done_tgl;
        rx_byte <= next_shreg;
      end
    end
  end

  // =====================================================================
  // link domain: table byte transmit on the falling edge
  logic [2:0] txcnt;
  logic [7:0] txsh;
  logic [7:0] hold_byte;

  always_ff @(negedge sclk_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in || cs_n_in) begin
      txcnt <= 3'h0;
      txsh <= 8'h00;
      so_out <= 1'b0;
      so_oe_n_out <= 1'b1;
    end else if (stream) begin
      so_oe_n_out <= 1'b0;
      txcnt <= txcnt + 3'h1;
      if (txcnt == 3'h0) begin
        so_out <= hold_byte[7];
        txsh <= {hold_byte[6:0], 1'b0};
      end else begin
        so_out <= txsh[7];
        txsh <= {txsh[6:0], 1'b0};
      end
    end
  end

  // =====================================================================
  // core domain: three-flop synchronisers for select and byte events
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic [2:0] sy3;
  logic [2:0] syf;
  logic [2:0] syf_d;
  logic cs_rise;
  logic cs_fall;
  logic ev_start;
  logic ev_done;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sy1 <= 3'h1;
      sy2 <= 3'h1;
      sy3 <= 3'h1;
      syf <= 3'h1;
      syf_d <= 3'h1;
    end else if (ce_in) begin
      sy1 <= {done_tgl, start_tgl, cs_n_in};
      sy2 <= sy1;
      sy3 <= sy2;
      for (int i = 0; i < 3; i++) begin
        if (sy2[i] == sy3[i]) begin
          syf[i] <= sy3[i];
        end
      end
      syf_d <= syf;
    end
  end

  assign cs_rise = ce_in && syf[0] && !syf_d[0];
  assign cs_fall = ce_in && !syf[0] && syf_d[0];
  assign ev_start = ce_in && (syf[1] != syf_d[1]);
  assign ev_done = ce_in && (syf[2] != syf_d[2]);

  // =====================================================================
  // core domain: frame tracking
  logic [2:0] nbytes;
  logic partial;
  logic [7:0] fr_op;
  logic [`FSPR_ADDR_W-1:0] fr_addr;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nbytes <= 3'h0;
      partial <= 1'b0;
      fr_op <= 8'h00;
      fr_addr <= '0;
    end else if (cs_fall) begin
      nbytes <= 3'h0;
      partial <= 1'b0;
    end else if (ev_done) begin
      partial <= 1'b0;
      if (nbytes != 3'h7) begin
        nbytes <= nbytes + 3'h1;
      end
      if (nbytes == 3'h0) begin
        fr_op <= rx_byte;
      end
      if (nbytes >= 3'h1 && nbytes <= 3'h3) begin
        fr_addr <= {fr_addr[`FSPR_ADDR_W-9:0], rx_byte};
      end
    end else if (ev_start) begin
      partial <= 1'b1;
    end
  end

  // table address walks one byte ahead of the link shifter
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      param_addr_out <= '0;
      hold_byte <= 8'h00;
    end else if (ce_in) begin
      if (ev_start && fr_op == `FSPR_OP_PARAM_RD) begin
        if (nbytes == `FSPR_PARAM_HDR - 3'h1) begin
          param_addr_out <= fr_addr;
        end else if (nbytes >= `FSPR_PARAM_HDR) begin
          param_addr_out <= param_addr_out + 1'b1;
        end
      end
      hold_byte <= param_byte_in;
    end
  end

  // =====================================================================
  // core domain: command decode at deselect
  logic ex_valid;
  logic [7:0] ex_op;
  logic soft_rst;
  logic gang_ok;
  logic refuse;
  logic resume_ok;
  logic rst_armed;
  logic write_enable_latch;
  logic write_in_progress;
  logic [15:0] lat_cnt;
  logic [15:0] next_lat;
  logic susp_erase;
  logic [`FSPR_ADDR_W-1:0] susp_addr;
  fspr_state_t st;

  // commands that must wait for the suspend latency
  function automatic logic needs_latency(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'hec, 8'hed, 8'hee, 8'h0c, 8'hbc, 8'h3c,
      8'h5a, 8'h9f, 8'haf, 8'hc0, 8'hb1, 8'hc1, 8'h06, 8'h30, 8'h2d, 8'he2, 8'h16, 8'he0,
      8'h35, 8'hf5, 8'h90: needs_latency = 1'b1;
      default: needs_latency = 1'b0;
    endcase
  endfunction : needs_latency

  // only a deselect exactly on a byte boundary executes a one-byte command
  assign ex_valid = cs_rise && !partial && nbytes == 3'h1;
  assign ex_op = fr_op;
  assign refuse = (st == FSPR_HALTING) && needs_latency(ex_op);
  assign soft_rst = ex_valid && ex_op == `FSPR_OP_RST && rst_armed;
  assign gang_ok = ex_valid && protect_select_in && write_enable_latch;
  assign resume_ok = ex_valid && !refuse && ex_op == `FSPR_OP_RESUME && st == FSPR_HALTED && !perf_mode_in;
  assign next_lat = lat_cnt - 16'h0001;

  // reset arm: valid only for the very next command
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_armed <= 1'b0;
    end else if (ex_valid || (cs_rise && nbytes != 3'h0)) begin
      rst_armed <= ex_valid && ex_op == `FSPR_OP_RST_ARM;
    end
  end

  // volatile sector locks
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      volatile_lock_out <= `FSPR_VLOCK_RST;
    end else if (soft_rst) begin
      volatile_lock_out <= `FSPR_VLOCK_RST;
    end else if (gang_ok && ex_op == `FSPR_OP_GANG_LOCK) begin
      volatile_lock_out <= '1;
    end else if (gang_ok && ex_op == `FSPR_OP_GANG_UNLOCK) begin
      volatile_lock_out <= '0;
    end
  end

  // suspend state machine with latency counter
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= FSPR_IDLE;
      lat_cnt <= 16'h0000;
      susp_erase <= 1'b0;
      susp_addr <= '0;
    end else if (soft_rst) begin
      st <= FSPR_IDLE;
      lat_cnt <= 16'h0000;
    end else if (ce_in) begin
      case (st)
        FSPR_IDLE: begin
          if (pe_start_in) begin
            st <= FSPR_RUN;
            susp_erase <= pe_erase_in;
            susp_addr <= pe_addr_in;
          end
        end
        FSPR_RUN: begin
          if (pe_done_in) begin
            st <= FSPR_IDLE;
          end else if (ex_valid && ex_op == `FSPR_OP_SUSPEND) begin
            st <= FSPR_HALTING;
            lat_cnt <= susp_erase ? 16'(`FSPR_ESL_CYC) : 16'(`FSPR_PSL_CYC);
          end
        end
        FSPR_HALTING: begin
          lat_cnt <= next_lat;
          if (lat_cnt == 16'h0001) begin
            st <= FSPR_HALTED;
          end
        end
        FSPR_HALTED: begin
          if (resume_ok) begin
            st <= FSPR_RUN;
          end
        end
        default: st <= FSPR_IDLE;
      endcase
    end
  end

  // write-enable latch and busy flag
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
    end else if (soft_rst) begin
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
    end else if (ce_in) begin
      if (st == FSPR_RUN && pe_done_in) begin
        write_enable_latch <= 1'b0;
        write_in_progress <= 1'b0;
      end else if (st == FSPR_HALTING && lat_cnt == 16'h0001) begin
        write_enable_latch <= 1'b0;
        write_in_progress <= 1'b0;
      end else if (resume_ok) begin
        write_enable_latch <= 1'b1;
        write_in_progress <= 1'b1;
      end else if (st == FSPR_IDLE && pe_start_in) begin
        write_in_progress <= 1'b1;
      end else if (ex_valid && !refuse && ex_op == `FSPR_OP_WRITE_ENABLE_CMD) begin
        write_enable_latch <= 1'b1;
      end else if (ex_valid && (ex_op == `FSPR_OP_WRITE_DISABLE_CMD || ex_op == `FSPR_OP_GANG_LOCK
                                || ex_op == `FSPR_OP_GANG_UNLOCK)) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // =====================================================================
  // core domain: registered outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      writable_out <= '0;
      read_allowed_out <= 1'b1;
      status_out <= 8'h00;
      security_out <= 8'h00;
      pe_hold_out <= 1'b0;
      pe_abort_out <= 1'b0;
      cmd_fwd_out <= '0;
    end else if (ce_in) begin
      writable_out <= ~(volatile_lock_out | nonvolatile_lock_in);
      if (st == FSPR_HALTING || st == FSPR_HALTED) begin
        read_allowed_out <= susp_erase ?
          (rd_addr_in[`FSPR_ADDR_W-1:`FSPR_SECTOR_LSB] != susp_addr[`FSPR_ADDR_W-1:`FSPR_SECTOR_LSB]) :
          (rd_addr_in[`FSPR_ADDR_W-1:`FSPR_PAGE_LSB] != susp_addr[`FSPR_ADDR_W-1:`FSPR_PAGE_LSB]);
      end else begin
        read_allowed_out <= 1'b1;
      end
      status_out <= 8'h00;
      status_out[`FSPR_ST_WIP] <= write_in_progress;
      status_out[`FSPR_ST_WEL] <= write_enable_latch;
      security_out <= 8'h00;
      security_out[`FSPR_SEC_PSB] <= (st == FSPR_HALTED) && !susp_erase;
      security_out[`FSPR_SEC_ESB] <= (st == FSPR_HALTED) && susp_erase;
      pe_hold_out <= (st == FSPR_HALTING || st == FSPR_HALTED) && !soft_rst;
      pe_abort_out <= soft_rst && st != FSPR_IDLE;
      cmd_fwd_out.valid <= cs_rise && nbytes != 3'h0 && !(ex_valid && refuse) && !soft_rst;
      cmd_fwd_out.opcode <= fr_op;
    end
  end

  // =====================================================================
  // checks
  chk_gang_unlock: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ex_valid && ex_op == `FSPR_OP_GANG_UNLOCK && !protect_select_in && !soft_rst)
    |=> $stable(volatile_lock_out)) else $error("gang unlock acted without select");
  chk_gang_wel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ex_valid && ex_op == `FSPR_OP_GANG_LOCK && !write_enable_latch && !soft_rst)
    |=> $stable(volatile_lock_out)) else $error("gang lock acted without latch");
  chk_gang_boundary: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cs_rise && partial) |-> !ex_valid) else $error("command ran off byte boundary");
  chk_writable_map: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ce_in && $past(ce_in)) |-> (writable_out == ~($past(volatile_lock_out) | $past(nonvolatile_lock_in))))
    else $error("writable map wrong");
  chk_suspend_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st == FSPR_HALTING && lat_cnt == 16'h0001 && ce_in && !soft_rst)
    |=> !write_enable_latch ##1 (security_out[`FSPR_SEC_PSB] | security_out[`FSPR_SEC_ESB])) else $error("suspend flag missing");
  chk_resume_sets: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    resume_ok && ce_in |=> write_enable_latch && write_in_progress && st == FSPR_RUN) else $error("resume did not set latch");
  chk_resume_perf: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (perf_mode_in && st == FSPR_HALTED && !soft_rst) |=> st != FSPR_RUN) else $error("resume in enhance mode");
  chk_done_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st == FSPR_RUN && pe_done_in && ce_in && !soft_rst) |=> !write_enable_latch && !write_in_progress) else $error("done left latch set");
  chk_reset_arm: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    soft_rst |-> rst_armed && ex_op == `FSPR_OP_RST) else $error("reset without arm");
  chk_reset_locks: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    soft_rst |=> volatile_lock_out == `FSPR_VLOCK_RST && !write_enable_latch ##1 !pe_hold_out) else $error("reset left state");
  chk_reset_abort: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (soft_rst && ce_in && st == FSPR_RUN) |=> pe_abort_out ##1 !pe_abort_out) else $error("abort not pulsed");
  chk_latency_refuse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ex_valid && st == FSPR_HALTING && ex_op == `FSPR_OP_WRITE_ENABLE_CMD && ce_in) |=> !cmd_fwd_out.valid && !write_enable_latch)
    else $error("latency command accepted early");
endmodule : fspr_core

// *** test/fspr_host.sv ***
// Purpose: host controller model that drives command frames on the link
// Assumes: link clock idles low and stands still outside frames
// Notes: data changes on falling edges and the device samples on rising edges
`timescale 1ns/1ps
module fspr_host (
  output logic cs_n_out, // chip select, active low
  output logic sclk_out, // link clock
  output logic [3:0] sio_out, // data lines
  input wire logic so_in, // serial data from device
  input wire logic so_oe_n_in // device drives when low
);
  localparam int HALF = 32; // 64 ns link period
  // =====================================================================
  // idle levels
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sio_out = 4'h0;
  end
  // one link clock pulse
  task pulse();
    #HALF sclk_out = 1'b1;
    #HALF sclk_out = 1'b0;
  endtask : pulse
  // one whole byte, msb or high nibble first
  task put_byte(input logic [7:0] b, input logic quad);
    if (quad) begin
      sio_out = b[7:4];
      pulse();
      sio_out = b[3:0];
      pulse();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        sio_out = {~sio_out[3:1], b[i]};
        pulse();
      end
    end
  endtask : put_byte
  // one streamed byte, plus whether output was driven throughout
  task get_byte(output logic [7:0] b, output logic oe_n);
    oe_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #HALF sclk_out = 1'b1;
      b[i] = so_in;
      oe_n = oe_n | so_oe_n_in;
      #HALF sclk_out = 1'b0;
    end
  endtask : get_byte
  // frame open and close, with a settle gap after it
  task open_frame();
    cs_n_out = 1'b0;
    #HALF;
  endtask : open_frame
  task close_frame();
    #HALF cs_n_out = 1'b1;
    sio_out = ~sio_out;
    #400;
  endtask : close_frame
  // one-byte command, optionally one stray bit after it
  task frame(input logic [7:0] op, input logic quad, input logic xbit);
    open_frame();
    put_byte(op, quad);
    if (xbit) begin
      pulse();
    end
    close_frame();
  endtask : frame
endmodule : fspr_host

// *** test/tb_top.sv ***
// Purpose: self-checking bench of the suspend, protect and reset layer
// Assumes: fixed seed, link clock from the host model
// Notes: expectations come from bench functions and defines
`timescale 1ns/1ps
`include "fspr_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import fspr_pkg::*;
  logic mclk_in, rst_n_in, cs_n, sclk, so, so_oe_n, quad, perf, psel, pe_start, pe_erase, pe_done, e, oe;
  logic [3:0] sio;
  logic [15:0] nv, vl, wr;
  logic [27:0] pe_addr, rd_addr, paddr, a;
  logic [23:0] b;
  logic [7:0] pbyte, status, sec, rb, last_op;
  logic rd_ok, hold, abort;
  fspr_cmd_t fwd;
  int bad_count, checked, aborts;
  // =====================================================================
  // clock, table model, monitors
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  assign pbyte = paddr[7:0] ^ 8'h3c;
  always @(posedge mclk_in) begin
    if (abort === 1'b1) aborts++;
    if (fwd.valid === 1'b1) last_op <= fwd.opcode;
  end
  fspr_host u_host (.cs_n_out(cs_n), .sclk_out(sclk), .sio_out(sio), .so_in(so), .so_oe_n_in(so_oe_n));
  fspr_core u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n),
    .sio_in(sio), .so_out(so), .so_oe_n_out(so_oe_n), .quad_mode_in(quad), .perf_mode_in(perf),
    .protect_select_in(psel), .nonvolatile_lock_in(nv), .pe_start_in(pe_start), .pe_erase_in(pe_erase),
    .pe_done_in(pe_done), .pe_addr_in(pe_addr), .rd_addr_in(rd_addr), .param_byte_in(pbyte),
    .param_addr_out(paddr), .volatile_lock_out(vl), .writable_out(wr), .read_allowed_out(rd_ok),
    .status_out(status), .security_out(sec), .pe_hold_out(hold), .pe_abort_out(abort), .cmd_fwd_out(fwd));
  // =====================================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  task pulse_pe(input logic start);
    @(posedge mclk_in) begin
      pe_start <= start;
      pe_done <= ~start;
    end
    @(posedge mclk_in) begin
      pe_start <= 1'b0;
      pe_done <= 1'b0;
    end
    cyc(4);
  endtask : pulse_pe
  task gang(input logic sel, input logic xb, input logic write_enable_cmd, input logic [7:0] op, input logic [15:0] exp);
    @(posedge mclk_in) psel <= sel;
    if (write_enable_cmd) u_host.frame(`FSPR_OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
    u_host.frame(op, 1'b0, xb);
    `CHK(vl, exp)
    `CHK(wr, ~(exp | nv))
  endtask : gang
  function automatic logic [1:0] susp_bits(input logic erase);
    return erase ? 2'b10 : 2'b01;
  endfunction : susp_bits
  task finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // =====================================================================
  // watchdog
  initial begin
    #500000;
    bad_count++;
    finish_test();
  end
  // =====================================================================
  // main sequence
  initial begin
    {rst_n_in, quad, perf, psel, pe_start, pe_erase, pe_done} = 7'h00;
    {nv, pe_addr, rd_addr} = '0;
    bad_count = 0;
    checked = 0;
    aborts = 0;
    last_op = 8'h00;
    void'($urandom(32'h5bc2));
    cyc(10);
    rst_n_in <= 1'b1;
    cyc(5);
    `CHK(vl, `FSPR_VLOCK_RST)
    `CHK(rd_ok, 1'b1)
    @(posedge mclk_in) nv <= 16'($urandom);
    gang(1'b0, 1'b0, 1'b1, `FSPR_OP_GANG_UNLOCK, 16'hffff);
    gang(1'b1, 1'b0, 1'b0, `FSPR_OP_GANG_UNLOCK, 16'hffff);
    gang(1'b1, 1'b1, 1'b1, `FSPR_OP_GANG_UNLOCK, 16'hffff);
    gang(1'b1, 1'b0, 1'b1, `FSPR_OP_GANG_UNLOCK, 16'h0000);
    gang(1'b1, 1'b0, 1'b1, `FSPR_OP_GANG_LOCK, 16'hffff);
    gang(1'b1, 1'b0, 1'b1, `FSPR_OP_GANG_UNLOCK, 16'h0000);
    $display("test gang done");
    a = 28'($urandom);
    e = 1'($urandom);
    @(posedge mclk_in) begin
      pe_addr <= a;
      pe_erase <= e;
    end
    pulse_pe(1'b1);
    u_host.frame(`FSPR_OP_SUSPEND, 1'b0, 1'b0);
    u_host.frame(`FSPR_OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
    `CHK(last_op, `FSPR_OP_SUSPEND)
    u_host.frame(8'h05, 1'b0, 1'b0);
    `CHK(last_op, 8'h05)
    `CHK(sec[3:2], 2'b00)
    @(posedge mclk_in) rd_addr <= a ^ 28'h10;
    cyc(3);
    `CHK(rd_ok, 1'b0)
    @(posedge mclk_in) rd_addr <= a ^ 28'h100;
    cyc(3);
    `CHK(rd_ok, ~e)
    @(posedge mclk_in) rd_addr <= a ^ 28'h1000;
    cyc(3);
    `CHK(rd_ok, 1'b1)
    cyc(`FSPR_ESL_CYC);
    `CHK(sec[3:2], susp_bits(e))
    `CHK(status[1:0], 2'b00)
    @(posedge mclk_in) perf <= 1'b1;
    u_host.frame(`FSPR_OP_RESUME, 1'b0, 1'b0);
    `CHK(sec[3:2], susp_bits(e))
    @(posedge mclk_in) perf <= 1'b0;
    u_host.frame(`FSPR_OP_RESUME, 1'b0, 1'b0);
    `CHK(status[1:0], 2'b11)
    `CHK(sec[3:2], 2'b00)
    `CHK(hold, 1'b0)
    pulse_pe(1'b0);
    `CHK(status[1:0], 2'b00)
    $display("test suspend done");
    pulse_pe(1'b1);
    u_host.frame(`FSPR_OP_RST_ARM, 1'b0, 1'b0);
    u_host.frame(`FSPR_OP_NOP, 1'b0, 1'b0);
    u_host.frame(`FSPR_OP_RST, 1'b0, 1'b0);
    `CHK(aborts, 0)
    `CHK(vl, 16'h0000)
    @(posedge mclk_in) quad <= 1'b1;
    repeat (2) u_host.frame(`FSPR_OP_NOP, 1'b1, 1'b0);
    u_host.frame(`FSPR_OP_RST_ARM, 1'b1, 1'b0);
    u_host.frame(`FSPR_OP_RST, 1'b1, 1'b0);
    `CHK(aborts, 1)
    `CHK(vl, `FSPR_VLOCK_RST)
    @(posedge mclk_in) quad <= 1'b0;
    // mode crosses on link edges only: four idle clocks let serial settle
    u_host.open_frame();
    repeat (4) u_host.pulse();
    u_host.close_frame();
    $display("test reset done");
    b = 24'($urandom);
    u_host.open_frame();
    u_host.put_byte(`FSPR_OP_PARAM_RD, 1'b0);
    u_host.put_byte(b[23:16], 1'b0);
    u_host.put_byte(b[15:8], 1'b0);
    u_host.put_byte(b[7:0], 1'b0);
    u_host.put_byte(8'h00, 1'b0);
    u_host.get_byte(rb, oe);
    `CHK(rb, b[7:0] ^ 8'h3c)
    u_host.get_byte(rb, oe);
    `CHK(rb, (b[7:0] + 8'h01) ^ 8'h3c)
    `CHK(oe, 1'b0)
    u_host.close_frame();
    `CHK(so_oe_n, 1'b1)
    $display("test param read done");
    finish_test();
  end
endmodule : tb_top
